// [hw/vpiu_arbiter.sv]
// priority search over all eligible requests, lowest request number wins a tie
`timescale 1ns/1ps
module vpiu_arbiter #(
  parameter int N = 118
) (
  // candidates
  input wire logic [N-1:0] eligible,
  input wire logic [N-1:0][2:0] prio,
  // current core level
  input wire logic [3:0] cur_level,
  // winner
  output logic win_valid,
  output logic [6:0] win_idx,
  output logic [2:0] win_prio
);
  always_comb begin
    win_valid = 1'b0;
    win_idx = 7'h00;
    win_prio = 3'h0;
    // descending scan with >= leaves the lowest number on a tie
    for (int i = N - 1; i >= 0; i--) begin
      if (eligible[i] && ({1'b0, prio[i]} > cur_level) &&
          (!win_valid || prio[i] >= win_prio)) begin
        win_valid = 1'b1;
        win_idx = 7'(i);
        win_prio = prio[i];
      end
    end
  end
endmodule

// [hw/vpiu_pkg.sv]
// shared constants, address map and carrier types of the vectored priority interrupt unit
package vpiu_pkg;
  localparam int NUM_REQ = 118;
  localparam int VEC_OFFSET = 8;
  localparam int PRIO_W = 3;
  localparam int DATA_W = 16;
  localparam logic [23:0] PRIMARY_BASE = 24'h000014;
  localparam logic [23:0] ALT_DISTANCE = 24'h000100;

  // request numbers of the named sources
  localparam int REQ_EXT_ZERO = 0;
  localparam int REQ_SERIAL_RX = 11;
  localparam int REQ_SERIAL_TX = 12;
  localparam int REQ_ADC_GROUP = 13;
  localparam int REQ_CMP_ONE = 18;
  localparam int REQ_CHANGE_NOTIFY = 19;
  localparam int REQ_EXT_ONE = 20;
  localparam int REQ_EXT_TWO = 29;
  localparam int REQ_PWM_SPECIAL = 57;
  localparam int REQ_SERIAL_ERR = 65;
  localparam int REQ_PWM_GEN_FIRST = 94;
  localparam int REQ_CMP_MORE_FIRST = 103;
  localparam int REQ_ADC_PAIR_FIRST = 110;
  localparam int REQ_LAST = 117;

  // byte offsets on the register bus
  localparam logic [11:0] OFS_CTRL_ONE = 12'h000;
  localparam logic [11:0] OFS_CTRL_TWO = 12'h004;
  localparam logic [11:0] OFS_STATUS = 12'h008;
  localparam logic [11:0] OFS_CORE_CTRL = 12'h00c;
  localparam logic [11:0] OFS_PENDING = 12'h010;
  localparam logic [11:0] OFS_FLAG_BASE = 12'h040;
  localparam logic [11:0] OFS_ENABLE_BASE = 12'h080;
  localparam logic [11:0] OFS_PRIO_BASE = 12'h100;
  localparam int NUM_BIT_REGS = 8;
  localparam int NUM_PRIO_REGS = 30;

  // field positions and writable masks
  localparam int NESTING_DISABLE_BIT = 15;
  localparam int ALT_TABLE_BIT = 15;
  localparam int LEVEL_LSB = 5;
  localparam int LEVEL_MSB_BIT = 3;
  localparam int PEND_LEVEL_LSB = 8;
  localparam logic [15:0] CTRL_ONE_MASK = 16'hffde;
  localparam logic [15:0] CTRL_TWO_MASK = 16'h8007;

  // reset values
  localparam logic [15:0] CTRL_ONE_RST = 16'h0000;
  localparam logic [15:0] CTRL_TWO_RST = 16'h0000;
  localparam logic [2:0] LEVEL_RST = 3'h0;
  localparam logic [2:0] PRIO_RST = 3'h0;

  typedef struct packed {
    logic [10:0] misc;
    logic serial_rx;
    logic serial_tx;
    logic serial_err;
    logic [3:0] pwm_gen;
    logic pwm_special;
    logic adc_group;
    logic [6:0] adc_pair;
    logic cmp_one;
    logic [2:0] cmp_more;
    logic change_notify;
  } vpiu_periph_t;

  typedef struct packed {
    logic req;
    logic [6:0] vector;
    logic [3:0] level;
    logic [23:0] addr;
  } vpiu_core_req_t;

  function automatic logic is_impl(input int n);
    return (n <= 3) || (n >= 5 && n <= 13) || (n >= 16 && n <= 20) || n == 29 ||
           n == 57 || n == 65 || (n >= 94 && n <= 97) || (n >= 103 && n <= 105) ||
           (n >= 110 && n <= 116);
  endfunction

  function automatic logic [NUM_REQ-1:0] impl_mask();
    logic [NUM_REQ-1:0] m;
    m = '0;
    for (int i = 0; i < NUM_REQ; i++) begin
      m[i] = is_impl(i);
    end
    return m;
  endfunction

  localparam logic [NUM_REQ-1:0] IMPL_MASK = impl_mask();

  function automatic logic [23:0] vec_addr(input logic [6:0] req, input logic alt);
    logic [23:0] a;
    a = PRIMARY_BASE + {16'h0000, req, 1'b0};
    return alt ? a + ALT_DISTANCE : a;
  endfunction

  function automatic logic [11:0] word_addr(input logic [11:0] base, input int idx);
    return base + 12'(idx * 4);
  endfunction
endpackage

// [hw/vpiu_top.sv]
// interrupt controller core: flags, enables, priorities, arbitration and apb registers
//
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
module vpiu_top (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // peripheral requests, same clock
  input wire vpiu_pkg::vpiu_periph_t periph_irq,
  // external interrupt pins, asynchronous
  input wire logic [2:0] ext_irq_pins,
  // trap hardware
  input wire logic [15:0] trap_events,
  input wire logic trap_level_set,
  input wire logic trap_level_clr,
  // core side
  output vpiu_pkg::vpiu_core_req_t core_irq,
  input wire logic core_irq_ack
);
  import vpiu_pkg::*;

  logic [NUM_REQ-1:0] flag_reg;
  logic [NUM_REQ-1:0] enable_reg;
  logic [NUM_REQ-1:0][2:0] prio_reg;
  logic [15:0] ctrl_one_reg;
  logic [15:0] ctrl_two_reg;
  logic [2:0] level_reg;
  logic level_msb_reg;
  logic [6:0] pend_vector_reg;
  logic [3:0] pend_level_reg;
  logic [2:0] pin_meta_reg;
  logic [2:0] pin_sync_reg;
  logic [2:0] pin_prev_reg;
  logic [NUM_REQ-1:0] req_vec;
  logic [2:0] ext_edge;
  logic win_valid;
  logic [6:0] win_idx;
  logic [2:0] win_prio;
  logic wr_acc;
  logic [31:0] rd_data;
  logic rd_ok;
  logic nesting_disable;
  logic alt_table_select;

  assign nesting_disable = ctrl_one_reg[NESTING_DISABLE_BIT];
  assign alt_table_select = ctrl_two_reg[ALT_TABLE_BIT];
  assign wr_acc = psel && penable && pwrite && pready;

  // external pins: two-stage sync, then edge with per-pin polarity
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta_reg <= 3'h0;
      pin_sync_reg <= 3'h0;
      pin_prev_reg <= 3'h0;
    end else begin
      pin_meta_reg <= ext_irq_pins;
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
    end
  end

  always_comb begin
    for (int p = 0; p < 3; p++) begin
      ext_edge[p] = ctrl_two_reg[p] ? (pin_prev_reg[p] && !pin_sync_reg[p]) :
                                      (!pin_prev_reg[p] && pin_sync_reg[p]);
    end
  end

  // source to request number mapping
  always_comb begin
    req_vec = '0;
    req_vec[REQ_EXT_ZERO] = ext_edge[0];
    req_vec[REQ_EXT_ONE] = ext_edge[1];
    req_vec[REQ_EXT_TWO] = ext_edge[2];
    req_vec[3:1] = periph_irq.misc[2:0];
    req_vec[10:5] = periph_irq.misc[8:3];
    req_vec[17:16] = periph_irq.misc[10:9];
    req_vec[REQ_SERIAL_RX] = periph_irq.serial_rx;
    req_vec[REQ_SERIAL_TX] = periph_irq.serial_tx;
    req_vec[REQ_SERIAL_ERR] = periph_irq.serial_err;
    req_vec[REQ_PWM_GEN_FIRST +: 4] = periph_irq.pwm_gen;
    req_vec[REQ_PWM_SPECIAL] = periph_irq.pwm_special;
    req_vec[REQ_ADC_PAIR_FIRST +: 7] = periph_irq.adc_pair;
    req_vec[REQ_ADC_GROUP] = periph_irq.adc_group;
    req_vec[REQ_CMP_ONE] = periph_irq.cmp_one;
    req_vec[REQ_CMP_MORE_FIRST +: 3] = periph_irq.cmp_more;
    req_vec[REQ_CHANGE_NOTIFY] = periph_irq.change_notify;
  end

  // flags: software write stores, a request in the same cycle still sets
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_reg <= '0;
    end else begin
      for (int i = 0; i < NUM_REQ; i++) begin
        if (IMPL_MASK[i]) begin
          if (req_vec[i]) begin
            flag_reg[i] <= 1'b1;
          end else if (wr_acc && paddr == word_addr(OFS_FLAG_BASE, i / 16)) begin
            flag_reg[i] <= pwdata[i % 16];
          end
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_reg <= '0;
    end else begin
      for (int i = 0; i < NUM_REQ; i++) begin
        if (IMPL_MASK[i] && wr_acc && paddr == word_addr(OFS_ENABLE_BASE, i / 16)) begin
          enable_reg[i] <= pwdata[i % 16];
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prio_reg <= '0;
    end else begin
      for (int i = 0; i < NUM_REQ; i++) begin
        if (IMPL_MASK[i] && wr_acc && paddr == word_addr(OFS_PRIO_BASE, i / 4)) begin
          prio_reg[i] <= pwdata[4 * (i % 4) +: 3];
        end
      end
    end
  end

  // global controls
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_one_reg <= CTRL_ONE_RST;
      ctrl_two_reg <= CTRL_TWO_RST;
    end else begin
      if (wr_acc && paddr == OFS_CTRL_TWO) begin
        ctrl_two_reg <= pwdata[15:0] & CTRL_TWO_MASK;
      end
      if (wr_acc && paddr == OFS_CTRL_ONE) begin
        ctrl_one_reg <= (pwdata[15:0] | trap_events) & CTRL_ONE_MASK;
      end else begin
        ctrl_one_reg <= (ctrl_one_reg | trap_events) & CTRL_ONE_MASK;
      end
    end
  end

  // core level: software writes unless frozen, accept raises it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_reg <= LEVEL_RST;
    end else if (core_irq_ack && core_irq.req) begin
      level_reg <= core_irq.level[2:0];
    end else if (wr_acc && paddr == OFS_STATUS && !nesting_disable) begin
      level_reg <= pwdata[LEVEL_LSB +: 3];
    end
  end

  // level msb ignores the bus, only trap hardware moves it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_msb_reg <= 1'b0;
    end else if (trap_level_set) begin
      level_msb_reg <= 1'b1;
    end else if (trap_level_clr) begin
      level_msb_reg <= 1'b0;
    end
  end

  vpiu_arbiter #(
    .N(NUM_REQ)
  ) u_arbiter (
    .eligible(flag_reg & enable_reg & IMPL_MASK),
    .prio(prio_reg),
    .cur_level({level_msb_reg, level_reg}),
    .win_valid(win_valid),
    .win_idx(win_idx),
    .win_prio(win_prio)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_irq <= '0;
    end else begin
      core_irq.req <= win_valid;
      core_irq.vector <= win_idx + 7'(VEC_OFFSET);
      core_irq.level <= {1'b0, win_prio};
      core_irq.addr <= vec_addr(win_idx, alt_table_select);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_vector_reg <= 7'h00;
      pend_level_reg <= 4'h0;
    end else if (core_irq_ack && core_irq.req) begin
      pend_vector_reg <= core_irq.vector;
      pend_level_reg <= core_irq.level;
    end
  end

  // read decode
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_ok = 1'b0;
    if (paddr == OFS_CTRL_ONE) begin
      rd_ok = 1'b1;
      rd_data[15:0] = ctrl_one_reg;
    end
    if (paddr == OFS_CTRL_TWO) begin
      rd_ok = 1'b1;
      rd_data[15:0] = ctrl_two_reg;
    end
    if (paddr == OFS_STATUS) begin
      rd_ok = 1'b1;
      rd_data[LEVEL_LSB +: 3] = level_reg;
    end
    if (paddr == OFS_CORE_CTRL) begin
      rd_ok = 1'b1;
      rd_data[LEVEL_MSB_BIT] = level_msb_reg;
    end
    if (paddr == OFS_PENDING) begin
      rd_ok = 1'b1;
      rd_data[6:0] = pend_vector_reg;
      rd_data[PEND_LEVEL_LSB +: 4] = pend_level_reg;
    end
    for (int r = 0; r < NUM_BIT_REGS; r++) begin
      if (paddr == word_addr(OFS_FLAG_BASE, r) || paddr == word_addr(OFS_ENABLE_BASE, r)) begin
        rd_ok = 1'b1;
      end
    end
    for (int r = 0; r < NUM_PRIO_REGS; r++) begin
      if (paddr == word_addr(OFS_PRIO_BASE, r)) begin
        rd_ok = 1'b1;
      end
    end
    for (int i = 0; i < NUM_REQ; i++) begin
      if (paddr == word_addr(OFS_FLAG_BASE, i / 16)) begin
        rd_data[i % 16] = flag_reg[i];
      end
      if (paddr == word_addr(OFS_ENABLE_BASE, i / 16)) begin
        rd_data[i % 16] = enable_reg[i];
      end
      if (paddr == word_addr(OFS_PRIO_BASE, i / 4)) begin
        rd_data[4 * (i % 4) +: 3] = prio_reg[i];
      end
    end
  end

  // apb: one wait-free access cycle, answer prepared in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !rd_ok;
      prdata <= (psel && !penable && !pwrite) ? rd_data : 32'h0000_0000;
    end
  end

  // checks
  property p_vec_number;
    @(posedge pclk) disable iff (!presetn)
      core_irq.req |-> core_irq.vector == $past(win_idx) + 7'h08;
  endproperty
  a_vec_number: assert property (p_vec_number) else $error("vector not request plus 8");

  property p_alt_addr;
    @(posedge pclk) disable iff (!presetn)
      core_irq.req |-> core_irq.addr == 24'h000014 + {16'h0000, core_irq.vector - 7'h08, 1'b0} +
                                        ($past(alt_table_select) ? 24'h000100 : 24'h000000);
  endproperty
  a_alt_addr: assert property (p_alt_addr) else $error("table address wrong");

  property p_flag_set;
    @(posedge pclk) disable iff (!presetn)
      periph_irq.serial_rx |=> flag_reg[11] ##1 flag_reg[11] || $past(wr_acc);
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("receive flag not set");

  property p_enabled_only;
    @(posedge pclk) disable iff (!presetn)
      core_irq.req |-> $past(enable_reg[win_idx]) && $past(flag_reg[win_idx]);
  endproperty
  a_enabled_only: assert property (p_enabled_only) else $error("disabled source presented");

  property p_above_level;
    @(posedge pclk) disable iff (!presetn)
      core_irq.req |-> core_irq.level > {$past(level_msb_reg), $past(level_reg)};
  endproperty
  a_above_level: assert property (p_above_level) else $error("level not above core");

  property p_blocked;
    @(posedge pclk) disable iff (!presetn)
      (level_msb_reg || level_reg == 3'h7) |=> !core_irq.req;
  endproperty
  a_blocked: assert property (p_blocked) else $error("request while blocked");

  property p_nest_freeze;
    @(posedge pclk) disable iff (!presetn)
      (nesting_disable && wr_acc && paddr == OFS_STATUS && !core_irq_ack) |=> $stable(level_reg);
  endproperty
  a_nest_freeze: assert property (p_nest_freeze) else $error("level written while frozen");

  property p_msb_ro;
    @(posedge pclk) disable iff (!presetn)
      (wr_acc && paddr == OFS_CORE_CTRL && !trap_level_set && !trap_level_clr) |=>
        $stable(level_msb_reg);
  endproperty
  a_msb_ro: assert property (p_msb_ro) else $error("level msb moved by software");

  property p_latch;
    @(posedge pclk) disable iff (!presetn)
      (core_irq_ack && core_irq.req) |=>
        pend_vector_reg == $past(core_irq.vector) && pend_level_reg == $past(core_irq.level);
  endproperty
  a_latch: assert property (p_latch) else $error("pending vector not latched");

  property p_reserved;
    @(posedge pclk) disable iff (!presetn)
      !flag_reg[4] && !enable_reg[14] && prio_reg[117] == 3'h0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved slot set");

  c_request: cover property (@(posedge pclk) disable iff (!presetn) core_irq.req);
  c_accept: cover property (@(posedge pclk) disable iff (!presetn) core_irq_ack && core_irq.req);
  c_alt: cover property (@(posedge pclk) disable iff (!presetn) core_irq.req && alt_table_select);
  c_frozen: cover property (@(posedge pclk) disable iff (!presetn)
                            nesting_disable && wr_acc && paddr == OFS_STATUS);
endmodule

// [testbench/vpiu_core_model.sv]
// stand-in for the processor core: acknowledges a presented interrupt after a chosen wait
`timescale 1ns/1ps
module vpiu_core_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // bench control
  input wire logic ack_en,
  input wire logic [3:0] ack_wait,
  // core side
  input wire vpiu_pkg::vpiu_core_req_t core_irq,
  output logic core_irq_ack
);
  import vpiu_pkg::*;
  logic [3:0] wait_reg;
  // one ack pulse per request; the wait stands for the core finishing its current work
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_reg <= 4'h0;
      core_irq_ack <= 1'b0;
    end else begin
      core_irq_ack <= 1'b0;
      if (!ack_en || !core_irq.req || core_irq_ack) begin
        wait_reg <= 4'h0;
      end else if (wait_reg >= ack_wait) begin
        core_irq_ack <= 1'b1;
        wait_reg <= 4'h0;
      end else begin
        wait_reg <= wait_reg + 4'h1;
      end
    end
  end
endmodule

// [testbench/vpiu_top_tb.sv]
// self-checking bench for the vectored priority interrupt unit
`timescale 1ns/1ps
module vpiu_top_tb;
  import vpiu_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  vpiu_periph_t periph_irq = '0;
  logic [2:0] ext_irq_pins = '0;
  logic [15:0] trap_events = '0;
  logic trap_level_set = 1'b0;
  logic trap_level_clr = 1'b0;
  vpiu_core_req_t core_irq;
  logic core_irq_ack;
  logic ack_en = 1'b0;
  int errors = 0;
  int check_count = 0;
  // request served by each bit of the peripheral vector, lsb first
  int bit_req [32] = '{19, 103, 104, 105, 18, 110, 111, 112, 113, 114, 115, 116, 13, 57,
                       94, 95, 96, 97, 65, 12, 11, 1, 2, 3, 5, 6, 7, 8, 9, 10, 16, 17};

  always #12.5 pclk = ~pclk;

  vpiu_top i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .periph_irq(periph_irq), .ext_irq_pins(ext_irq_pins), .trap_events(trap_events),
    .trap_level_set(trap_level_set), .trap_level_clr(trap_level_clr),
    .core_irq(core_irq), .core_irq_ack(core_irq_ack)
  );

  vpiu_core_model i_core (
    .pclk(pclk), .presetn(presetn), .ack_en(ack_en), .ack_wait(4'h3),
    .core_irq(core_irq), .core_irq_ack(core_irq_ack)
  );

  task automatic finish_test();
    if (errors == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_core(input vpiu_core_req_t exp);
    check_count++;
    if (core_irq !== exp) begin
      errors++;
      $display("wrong value at %0t: core request %h expected %h", $time, core_irq, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
      if (n > 16) begin
        errors++;
        finish_test();
      end
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] wd);
    logic [31:0] d;
    logic e;
    apb(1'b1, a, wd, d, e);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic e;
    apb(1'b0, a, 32'h0, d, e);
    chk(d, exp, "read data");
  endtask

  function automatic logic [11:0] at(input logic [11:0] base, input int k);
    return base + 12'(k * 4);
  endfunction

  task automatic pulse(input int b);
    @(posedge pclk);
    periph_irq <= vpiu_periph_t'(32'h1 << b);
    @(posedge pclk);
    periph_irq <= '0;
  endtask

  task automatic settle();
    repeat (3) @(posedge pclk);
    #1;
  endtask

  task automatic chk_req(input logic exp);
    chk({31'h0, core_irq.req}, {31'h0, exp}, "request line");
  endtask

  initial begin
    logic [31:0] d;
    logic e;
    int n;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFS_CTRL_ONE, 32'h0);
    rd(OFS_CTRL_TWO, 32'h0);
    rd(OFS_STATUS, 32'h0);
    rd(OFS_PENDING, 32'h0);
    chk_req(1'b0);
    apb(1'b0, 12'h060, 32'h0, d, e);
    chk({31'h0, e}, 32'h1, "error flag");
    chk(d, 32'h0, "refused data");
    // implemented bits only, three-bit priority fields
    wr(OFS_PRIO_BASE, 32'hffff);
    rd(OFS_PRIO_BASE, 32'h7777);
    wr(at(OFS_PRIO_BASE, 1), 32'hffff);
    rd(at(OFS_PRIO_BASE, 1), 32'h7770);
    wr(OFS_FLAG_BASE, 32'hffff);
    rd(OFS_FLAG_BASE, 32'h3fef);
    wr(OFS_FLAG_BASE, 32'h0);
    wr(OFS_ENABLE_BASE, 32'hffff);
    rd(OFS_ENABLE_BASE, 32'h3fef);
    for (int k = 0; k < NUM_PRIO_REGS; k++) wr(at(OFS_PRIO_BASE, k), 32'h1111);
    for (int k = 0; k < NUM_BIT_REGS; k++) wr(at(OFS_ENABLE_BASE, k), 32'hffff);
    // every peripheral source alone: flag place, vector and table entry
    for (int b = 0; b < 32; b++) begin
      n = bit_req[b];
      pulse(b);
      settle();
      rd(at(OFS_FLAG_BASE, n / 16), 32'h1 << (n % 16));
      chk_core({1'b1, 7'(n + 8), 4'h1, 24'h000014 + 24'(2 * n)});
      wr(at(OFS_FLAG_BASE, n / 16), 32'h0);
    end
    // external pins, rising edge by default
    for (int p = 0; p < 3; p++) begin
      n = (p == 0) ? 0 : (p == 1) ? 20 : 29;
      @(posedge pclk);
      ext_irq_pins[p] <= 1'b1;
      repeat (4) @(posedge pclk);
      #1;
      chk_core({1'b1, 7'(n + 8), 4'h1, 24'h000014 + 24'(2 * n)});
      @(posedge pclk);
      ext_irq_pins[p] <= 1'b0;
      rd(at(OFS_FLAG_BASE, n / 16), 32'h1 << (n % 16));
      wr(at(OFS_FLAG_BASE, n / 16), 32'h0);
    end
    // falling edge selected for pin one: a rise must not flag, the fall must
    wr(OFS_CTRL_TWO, 32'h0002);
    @(posedge pclk);
    ext_irq_pins[1] <= 1'b1;
    settle();
    rd(at(OFS_FLAG_BASE, 1), 32'h0);
    ext_irq_pins[1] <= 1'b0;
    settle();
    rd(at(OFS_FLAG_BASE, 1), 32'h0010);
    wr(at(OFS_FLAG_BASE, 1), 32'h0);
    wr(OFS_CTRL_TWO, 32'h0);
    // tie, priority, enable and core level
    wr(OFS_FLAG_BASE, 32'h1800);
    settle();
    chk_core({1'b1, 7'd19, 4'h1, 24'h00002a});
    wr(at(OFS_PRIO_BASE, 3), 32'h1112);
    settle();
    chk_core({1'b1, 7'd20, 4'h2, 24'h00002c});
    wr(OFS_ENABLE_BASE, 32'hefff);
    settle();
    chk_core({1'b1, 7'd19, 4'h1, 24'h00002a});
    wr(OFS_STATUS, 32'h20);
    rd(OFS_STATUS, 32'h20);
    settle();
    chk_req(1'b0);
    wr(at(OFS_PRIO_BASE, 2), 32'h7111);
    settle();
    chk_core({1'b1, 7'd19, 4'h7, 24'h00002a});
    wr(OFS_STATUS, 32'he0);
    settle();
    chk_req(1'b0);
    wr(OFS_STATUS, 32'h0);
    @(posedge pclk);
    trap_level_set <= 1'b1;
    @(posedge pclk);
    trap_level_set <= 1'b0;
    settle();
    chk_req(1'b0);
    wr(OFS_CORE_CTRL, 32'h0);
    rd(OFS_CORE_CTRL, 32'h8);
    @(posedge pclk);
    trap_level_clr <= 1'b1;
    @(posedge pclk);
    trap_level_clr <= 1'b0;
    wr(OFS_CTRL_TWO, 32'h8000);
    rd(OFS_CTRL_TWO, 32'h8000);
    settle();
    chk_core({1'b1, 7'd19, 4'h7, 24'h00012a});
    // nesting disable freezes the level; trap flags land in control one
    wr(OFS_CTRL_ONE, 32'h8000);
    wr(OFS_STATUS, 32'h40);
    rd(OFS_STATUS, 32'h0);
    wr(OFS_CTRL_ONE, 32'h0);
    @(posedge pclk);
    trap_events <= 16'h0002;
    settle();
    rd(OFS_CTRL_ONE, 32'h0002);
    trap_events <= 16'h0000;
    wr(OFS_CTRL_ONE, 32'h0);
    rd(OFS_CTRL_ONE, 32'h0);
    // acceptance by the core
    wr(at(OFS_PRIO_BASE, 2), 32'h5111);
    ack_en <= 1'b1;
    repeat (12) @(posedge pclk);
    ack_en <= 1'b0;
    rd(OFS_PENDING, 32'h0513);
    rd(OFS_STATUS, 32'ha0);
    #1;
    chk_req(1'b0);
    rd(OFS_FLAG_BASE, 32'h1800);
    finish_test();
  end
endmodule
